// file: logic/wdss_pkg.sv
package wdss_pkg;
	// ==========================================================
	// register offsets
	localparam logic [3:0] ADDR_CON0  = 4'h0;
	localparam logic [3:0] ADDR_CON1  = 4'h1;
	localparam logic [3:0] ADDR_DBR   = 4'h2;
	localparam logic [3:0] ADDR_DBF   = 4'h3;
	localparam logic [3:0] ADDR_STEER = 4'h4;
	localparam logic [3:0] ADDR_AS0   = 4'h5;
	localparam logic [3:0] ADDR_AS1   = 4'h6;
	// ==========================================================
	// field positions
	localparam int CON0_EN_BIT   = 7;
	localparam int CON0_LD_BIT   = 6;
	localparam int AS0_SHUT_BIT  = 7;
	localparam int AS0_REN_BIT   = 6;
	localparam int AS0_OVERRIDE_LEVEL_BD_LSB  = 4;
	localparam int AS0_OVERRIDE_LEVEL_AC_LSB  = 2;
	localparam int CON1_IN_BIT   = 5;
	// ==========================================================
	// reset values
	localparam logic [7:0] CON0_RST  = 8'h00;
	localparam logic [7:0] AS0_RST   = 8'h14;
	localparam logic [5:0] AS1_RST   = 6'h00;
	localparam logic [5:0] DB_RST    = 6'h00;
	// ==========================================================
	// modes and override encodings
	localparam logic [2:0] MODE_STEER      = 3'h0;
	localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
	localparam logic [2:0] MODE_FWD        = 3'h2;
	localparam logic [2:0] MODE_REV        = 3'h3;
	localparam logic [2:0] MODE_HALF       = 3'h4;
	localparam logic [2:0] MODE_PUSH       = 3'h5;
	localparam logic [1:0] OVR_ONE         = 2'h3;
	localparam logic [1:0] OVR_ZERO        = 2'h2;
	localparam logic [1:0] OVR_TRI         = 2'h1;
	localparam logic [1:0] OVR_INACTIVE    = 2'h0;
endpackage

// file: logic/wdss_top.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Function
// - falling dead band delays B/D leading edge
// - disabled: falling value loads at once
// - enabled: load request applies at falling input
// - short input pulse gives no output in half-bridge mode
// - dead band jitter at most one clock
// - direction change waits for rising input
// - direction change: B/D held one dead band
// - steering: selected outputs follow input
// - polarity only on steered outputs
// - shutdown overrides only steered outputs
// - mode 000 steering applies immediately
// - mode 001 steering waits rising edge
// - software shutdown bit forces shutdown
// - active low sources force overrides at once
// - six individually enabled shutdown sources
// - sources level sensitive, hold shutdown
// - keeps running in sleep when enabled
// - override fields set levels, polarity only in inactive
// - manual clear refused while source active
// - auto restart clears when sources idle
// - control zero: enable, load, mode bits
// - load bit cleared by hardware after load
// - dead band counts clocks zero to value
// - override encoding one, zero, tri, inactive
// - disabled module leaves pins untouched
module wdss_top #(
	parameter int DB_W = 6
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       mod_in_i,
	input  wire logic       comparator_one_result_i,
	input  wire logic       comparator_two_result_i,
	input  wire logic       timer_two_postscaled_i,
	input  wire logic       timer_four_postscaled_i,
	input  wire logic       timer_six_postscaled_i,
	input  wire logic       external_input_pin_i,
	output logic      [3:0] out_o,
	output logic      [3:0] out_oe_n_o
);
	initial begin
		// counters and registers are built six bits wide
		if (DB_W != 6) $error("DB_W must be 6");
	end

	// ==========================================================
	// input synchronisers, three stages, accept when 2nd==3rd
	localparam int NSRC = 7;
	logic [NSRC-1:0] raw;
	logic [NSRC-1:0] s1_q, s2_q, s3_q, filt_q;
	assign raw = {mod_in_i, external_input_pin_i, timer_six_postscaled_i,
		timer_four_postscaled_i, timer_two_postscaled_i,
		comparator_two_result_i, comparator_one_result_i};
	genvar g;
	generate
		for (g = 0; g < NSRC; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_q[g] <= 1'b1;
					s2_q[g] <= 1'b1;
					s3_q[g] <= 1'b1;
					filt_q[g] <= (g == NSRC-1) ? 1'b0 : 1'b1;
				end else begin
					s1_q[g] <= raw[g];
					s2_q[g] <= s1_q[g];
					s3_q[g] <= s2_q[g];
					if (s2_q[g] == s3_q[g]) filt_q[g] <= s3_q[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// registers
	logic [7:0] con0_q;
	logic [3:0] pol_q;
	logic [5:0] dbr_q, dbf_q, dbr_act_q, dbf_act_q;
	logic [3:0] steer_q, steer_act_q;
	logic       shut_q, ren_q;
	logic [1:0] override_level_bd_q, override_level_ac_q;
	logic [5:0] as1_q;
	logic       in_q, in_d1_q;

	wire        en     = con0_q[wdss_pkg::CON0_EN_BIT];
	wire        ld     = con0_q[wdss_pkg::CON0_LD_BIT];
	wire  [2:0] mode   = con0_q[2:0];
	wire        steer_m = (mode[2:1] == 2'b00);
	wire        fb_m   = (mode[2:1] == 2'b01);
	wire        rise   = in_q & ~in_d1_q;
	wire        fall   = ~in_q & in_d1_q;
	wire        w_con0 = wr_i && addr_i == wdss_pkg::ADDR_CON0;
	wire        w_as0  = wr_i && addr_i == wdss_pkg::ADDR_AS0;
	wire        w_con1  = wr_i && addr_i == wdss_pkg::ADDR_CON1;
	wire        w_dbr   = wr_i && addr_i == wdss_pkg::ADDR_DBR;
	wire        w_dbf   = wr_i && addr_i == wdss_pkg::ADDR_DBF;
	wire        w_steer = wr_i && addr_i == wdss_pkg::ADDR_STEER;
	wire        w_as1   = wr_i && addr_i == wdss_pkg::ADDR_AS1;
	// sources are active low; each enabled separately
	wire  [5:0] src_act = ~filt_q[5:0] & as1_q;
	wire        src_any = |src_act;
	// a software clear is refused while any enabled source is low
	wire        sw_clr  = w_as0 && !wdata_i[wdss_pkg::AS0_SHUT_BIT];
	wire        shut_d  = src_any ? 1'b1
		: (w_as0 && wdata_i[wdss_pkg::AS0_SHUT_BIT]) ? 1'b1
		: (sw_clr || ren_q) ? 1'b0
		: shut_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_q <= 1'b0;
			in_d1_q <= 1'b0;
		end else begin
			in_q <= filt_q[NSRC-1];
			in_d1_q <= in_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			con0_q <= wdss_pkg::CON0_RST;
		end else if (w_con0) begin
			// load request only accepted once already enabled
			con0_q <= {wdata_i[7], wdata_i[6] & en, 3'h0, wdata_i[2:0]};
		end else if (ld && fall) begin
			con0_q[wdss_pkg::CON0_LD_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shut_q <= 1'b0;
		end else begin
			shut_q <= shut_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pol_q <= 4'h0;
		end else if (w_con1) begin
			pol_q <= wdata_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbr_q <= wdss_pkg::DB_RST;
		end else if (w_dbr) begin
			dbr_q <= wdata_i[5:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbf_q <= wdss_pkg::DB_RST;
		end else if (w_dbf) begin
			dbf_q <= wdata_i[5:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			steer_q <= 4'h0;
		end else if (w_steer) begin
			steer_q <= wdata_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ren_q <= 1'b0;
			override_level_bd_q <= wdss_pkg::AS0_RST[5:4];
			override_level_ac_q <= wdss_pkg::AS0_RST[3:2];
		end else if (w_as0) begin
			ren_q <= wdata_i[wdss_pkg::AS0_REN_BIT];
			override_level_bd_q <= wdata_i[5:4];
			override_level_ac_q <= wdata_i[3:2];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			as1_q <= wdss_pkg::AS1_RST;
		end else if (w_as1) begin
			as1_q <= wdata_i[5:0];
		end
	end

	// double buffered dead band values
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbr_act_q <= wdss_pkg::DB_RST;
			dbf_act_q <= wdss_pkg::DB_RST;
		end else if (!en) begin
			dbr_act_q <= dbr_q;
			dbf_act_q <= dbf_q;
		end else if (ld && fall) begin
			dbr_act_q <= dbr_q;
			dbf_act_q <= dbf_q;
		end
	end

	// steering: mode 000 tracks at once, 001 waits for rising input
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			steer_act_q <= 4'h0;
		end else if (mode == wdss_pkg::MODE_STEER || !en) begin
			steer_act_q <= steer_q;
		end else if (rise) begin
			steer_act_q <= steer_q;
		end
	end

	// ==========================================================
	// shutdown hold: overrides stay until rising edge after clear
	logic ovr_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_q <= 1'b0;
		end else if (shut_d) begin
			ovr_q <= 1'b1;
		end else if (rise) begin
			ovr_q <= 1'b0;
		end
	end

	// ==========================================================
	// direction latched at rising input, push-pull phase
	logic dir_q, dir_chg_q, pp_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_q <= 1'b0;
			dir_chg_q <= 1'b0;
			pp_q <= 1'b1;
		end else begin
			if (rise) begin
				dir_q <= mode[0];
				dir_chg_q <= (mode[0] != dir_q) && fb_m;
			end
			// toggling on the fall keeps the whole high phase on one side
			if (fall) pp_q <= ~pp_q;
			if (!en || ovr_q) pp_q <= 1'b1;
		end
	end

	// ==========================================================
	// dead band timers: count from zero up to the value
	logic [5:0] cnt_r_q, cnt_f_q;
	logic       del_r_q, del_f_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r_q <= 6'h0;
			cnt_f_q <= 6'h0;
			del_r_q <= 1'b0;
			del_f_q <= 1'b0;
		end else begin
			// restarts on each edge, so a short pulse never matures
			if (!in_q) begin
				cnt_r_q <= 6'h0;
				del_r_q <= 1'b0;
			end else if (cnt_r_q >= dbr_act_q) begin
				del_r_q <= 1'b1;
			end else begin
				cnt_r_q <= cnt_r_q + 6'h1;
			end
			if (in_q) begin
				cnt_f_q <= 6'h0;
				del_f_q <= 1'b0;
			end else if (cnt_f_q >= dbf_act_q) begin
				del_f_q <= 1'b1;
			end else begin
				cnt_f_q <= cnt_f_q + 6'h1;
			end
		end
	end

	// falling dead band value times the high phase after a turn to forward
	logic [5:0] cnt_h_q;
	logic       del_h_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || !in_q) begin
			cnt_h_q <= 6'h0;
			del_h_q <= 1'b0;
		end else if (cnt_h_q >= dbf_act_q) begin
			del_h_q <= 1'b1;
		end else begin
			cnt_h_q <= cnt_h_q + 6'h1;
		end
	end

	// ==========================================================
	// waveform per mode, true-level before polarity
	logic [3:0] wave;
	// the rise cycle must already show the new direction
	wire        dir_now = rise ? mode[0] : dir_q;
	wire        chg_now = rise ? ((mode[0] != dir_q) && fb_m) : dir_chg_q;
	always_comb begin
		wave = 4'h0;
		case (mode)
			wdss_pkg::MODE_HALF: wave = {~in_q & del_f_q, in_q & del_r_q,
				~in_q & del_f_q, in_q & del_r_q};
			wdss_pkg::MODE_PUSH: wave = {in_q & ~pp_q, in_q & pp_q, in_q & ~pp_q, in_q & pp_q};
			// forward: A on, D modulated; reverse: C on, B modulated
			wdss_pkg::MODE_FWD, wdss_pkg::MODE_REV: wave = dir_now ?
				{1'b0, 1'b1, in_q & (chg_now ? del_r_q : 1'b1), 1'b0}
				: {in_q & (chg_now ? del_h_q : 1'b1), 1'b0, 1'b0, 1'b1};
			default: wave = {4{in_q}} & steer_act_q;
		endcase
	end

	// ==========================================================
	// output stage
	logic [3:0] lvl, oe_n;
	generate
		for (g = 0; g < 4; g++) begin : g_out
			wire [1:0] ovr = (g % 2 == 1) ? override_level_bd_q : override_level_ac_q;
			wire hit = ovr_q && (!steer_m || steer_act_q[g]);
			wire fixed = steer_m && !steer_act_q[g];
			always_comb begin
				oe_n[g] = 1'b0;
				lvl[g] = fixed ? 1'b0 : (wave[g] ^ pol_q[g]);
				if (hit) begin
					case (ovr)
						wdss_pkg::OVR_ONE:  lvl[g] = 1'b1;
						wdss_pkg::OVR_ZERO: lvl[g] = 1'b0;
						wdss_pkg::OVR_TRI:  oe_n[g] = 1'b1;
						default:            lvl[g] = pol_q[g];
					endcase
				end
				if (!en) begin
					oe_n[g] = 1'b1;
					lvl[g] = 1'b0;
				end
			end
		end
	endgenerate

	// runs on clk_i alone, so sleep only stops it if clk_i stops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_o <= 4'h0;
			out_oe_n_o <= 4'hf;
		end else begin
			out_o <= lvl;
			out_oe_n_o <= oe_n;
		end
	end

	// ==========================================================
	// read port, data one cycle after strobe
	logic [7:0] rmux;
	always_comb begin
		case (addr_i)
			wdss_pkg::ADDR_CON0:  rmux = con0_q;
			wdss_pkg::ADDR_CON1:  rmux = {2'h0, in_q, 1'b0, pol_q};
			wdss_pkg::ADDR_DBR:   rmux = {2'h0, dbr_q};
			wdss_pkg::ADDR_DBF:   rmux = {2'h0, dbf_q};
			wdss_pkg::ADDR_STEER: rmux = {4'h0, steer_q};
			wdss_pkg::ADDR_AS0:   rmux = {shut_q, ren_q, override_level_bd_q, override_level_ac_q, 2'h0};
			wdss_pkg::ADDR_AS1:   rmux = {2'h2, as1_q};
			default:              rmux = 8'h00;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) rdata_o <= 8'h00;
		else if (rd_i) rdata_o <= rmux;
		else rdata_o <= 8'h00;
	end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic       clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       mod_in_i = 1'b1;
	logic       cmp1_n = 1'b1;
	logic [7:0] rdata_o;
	logic [3:0] out_o;
	logic [3:0] out_oe_n_o;
	logic [3:0] gate;
	int         mismatches = 0;
	int         total_checks = 0;
	int         cyc = 0;
	wdss_top u_wdss_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mod_in_i(mod_in_i),
		.comparator_one_result_i(cmp1_n), .comparator_two_result_i(1'b1),
		.timer_two_postscaled_i(1'b1), .timer_four_postscaled_i(1'b1),
		.timer_six_postscaled_i(1'b1), .external_input_pin_i(1'b1),
		.out_o(out_o), .out_oe_n_o(out_oe_n_o));
	wdss_bridge_model u_wdss_bridge_model (.drv_i(out_o), .drv_oe_n_i(out_oe_n_o),
		.gate_o(gate));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// ==========
	// bus and compare helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, e);
	endtask
	task automatic ck(input logic [7:0] e);
		repeat (8) @(posedge clk_i);
		@(negedge clk_i);
		chk({out_oe_n_o, out_o}, e);
	endtask
	// input path is a few cycles deep, so settle before looking
	task automatic mv(input logic v);
		@(posedge clk_i);
		mod_in_i <= v;
		repeat (14) @(posedge clk_i);
	endtask
	task automatic till(input int i, input logic v, input int lim, output int k);
		k = 0;
		while (out_o[i] !== v && k < lim) begin
			@(negedge clk_i);
			k++;
		end
	endtask
	task automatic db(input int n);
		int a;
		int b;
		@(posedge clk_i);
		mod_in_i <= 1'b0;
		till(0, 1'b0, 40, a);
		till(1, 1'b1, 90, b);
		chk(8'(b >= n && b <= n + 2), 8'h01);
		mv(1'b1);
	endtask
	// ==========
	// scenarios
	task automatic t_regs();
		rd(wdss_pkg::ADDR_CON0, wdss_pkg::CON0_RST);
		rd(wdss_pkg::ADDR_AS0, wdss_pkg::AS0_RST);
		rd(wdss_pkg::ADDR_AS1, 8'h80);
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		wr(wdss_pkg::ADDR_CON0, 8'h44);
		rd(wdss_pkg::ADDR_CON0, 8'h04);
		ck(8'hf0);
	endtask
	task automatic t_dead();
		int k;
		wr(wdss_pkg::ADDR_DBF, 8'h04);
		wr(wdss_pkg::ADDR_CON0, 8'h84);
		mv(1'b1);
		db(4);
		wr(wdss_pkg::ADDR_DBF, 8'h0a);
		wr(wdss_pkg::ADDR_CON0, 8'hc4);
		rd(wdss_pkg::ADDR_CON0, 8'hc4);
		db(10);
		rd(wdss_pkg::ADDR_CON0, 8'h84);
		@(posedge clk_i);
		mod_in_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		mod_in_i <= 1'b1;
		till(1, 1'b1, 30, k);
		chk(8'(k), 8'd30);
	endtask
	task automatic t_shut();
		wr(wdss_pkg::ADDR_AS1, 8'h01);
		wr(wdss_pkg::ADDR_AS0, 8'h28);
		cmp1_n <= 1'b0;
		ck(8'h00);
		chk({4'h0, gate}, 8'h00);
		wr(wdss_pkg::ADDR_AS0, 8'h28);
		rd(wdss_pkg::ADDR_AS0, 8'ha8);
		@(posedge clk_i);
		cmp1_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		wr(wdss_pkg::ADDR_AS0, 8'h28);
		rd(wdss_pkg::ADDR_AS0, 8'h28);
		ck(8'h00);
		mv(1'b0);
		mv(1'b1);
		ck(8'h05);
		wr(wdss_pkg::ADDR_AS0, 8'ha4);
		ck(8'h55);
		wr(wdss_pkg::ADDR_AS0, 8'h68);
		cmp1_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		rd(wdss_pkg::ADDR_AS0, 8'he8);
		@(posedge clk_i);
		cmp1_n <= 1'b1;
		ck(8'h00);
		rd(wdss_pkg::ADDR_AS0, 8'h68);
		mv(1'b0);
		mv(1'b1);
		ck(8'h05);
	endtask
	task automatic t_steer();
		wr(wdss_pkg::ADDR_CON1, 8'h02);
		wr(wdss_pkg::ADDR_STEER, 8'h03);
		wr(wdss_pkg::ADDR_CON0, 8'h80);
		mv(1'b1);
		ck(8'h01);
		mv(1'b0);
		ck(8'h02);
		wr(wdss_pkg::ADDR_STEER, 8'h01);
		ck(8'h00);
		mv(1'b1);
		wr(wdss_pkg::ADDR_CON0, 8'h81);
		wr(wdss_pkg::ADDR_STEER, 8'h04);
		ck(8'h01);
		mv(1'b0);
		mv(1'b1);
		ck(8'h04);
	endtask
	task automatic t_bridge();
		int k;
		wr(wdss_pkg::ADDR_CON1, 8'h00);
		wr(wdss_pkg::ADDR_CON0, 8'h02);
		wr(wdss_pkg::ADDR_DBR, 8'h04);
		wr(wdss_pkg::ADDR_DBF, 8'h08);
		wr(wdss_pkg::ADDR_CON0, 8'h82);
		mv(1'b0);
		ck(8'h04);
		@(posedge clk_i);
		mod_in_i <= 1'b1;
		till(0, 1'b1, 40, k);
		till(3, 1'b1, 40, k);
		chk(8'(k >= 8 && k <= 10), 8'h01);
		ck(8'h09);
		wr(wdss_pkg::ADDR_CON0, 8'h83);
		ck(8'h09);
		mv(1'b0);
		ck(8'h01);
		@(posedge clk_i);
		mod_in_i <= 1'b1;
		till(2, 1'b1, 40, k);
		till(1, 1'b1, 40, k);
		chk(8'(k >= 4 && k <= 6), 8'h01);
		mv(1'b0);
		@(posedge clk_i);
		mod_in_i <= 1'b1;
		repeat (7) @(posedge clk_i);
		@(negedge clk_i);
		chk({7'h0, out_o[1]}, 8'h01);
		wr(wdss_pkg::ADDR_CON0, 8'h05);
		wr(wdss_pkg::ADDR_CON0, 8'h85);
		mv(1'b0);
		mv(1'b1);
		ck(8'h0a);
		mv(1'b0);
		mv(1'b1);
		ck(8'h05);
	endtask
	// ==========
	// run control
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_dead();
		t_shut();
		t_steer();
		t_bridge();
		final_report();
	end
endmodule
`default_nettype wire

// file: verification/wdss_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdss_bridge_model (
	input  wire logic [3:0] drv_i,
	input  wire logic [3:0] drv_oe_n_i,
	output logic      [3:0] gate_o
);
	// ==========
	// a released gate line floats: show the inverse of its last level
	logic [3:0] last_q = 4'h0;
	always @(drv_i or drv_oe_n_i) begin
		last_q = (drv_i & ~drv_oe_n_i) | (last_q & drv_oe_n_i);
	end
	assign gate_o = (drv_i & ~drv_oe_n_i) | (~last_q & drv_oe_n_i);
endmodule
`default_nettype wire

// file: verification/wdss_props.sv
`timescale 1ns/1ps
`default_nettype none
module wdss_props #(
	parameter int DB_W = 6
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       comparator_one_result_i,
	input wire logic       comparator_two_result_i,
	input wire logic       timer_two_postscaled_i,
	input wire logic       timer_four_postscaled_i,
	input wire logic       timer_six_postscaled_i,
	input wire logic       external_input_pin_i,
	input wire logic [3:0] out_o,
	input wire logic [3:0] out_oe_n_o
);
	// ==========
	// shadow of written fields; hardware-set bits are left out
	logic [7:0] con0_q;
	logic [7:0] as0_q;
	logic [5:0] as1_q;
	logic [3:0] str_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			con0_q <= wdss_pkg::CON0_RST;
			as0_q  <= wdss_pkg::AS0_RST;
			as1_q  <= wdss_pkg::AS1_RST;
			str_q  <= 4'h0;
		end else if (wr_i) begin
			case (addr_i)
				wdss_pkg::ADDR_CON0:  con0_q <= wdata_i;
				wdss_pkg::ADDR_AS0:   as0_q <= wdata_i;
				wdss_pkg::ADDR_AS1:   as1_q <= wdata_i[5:0];
				wdss_pkg::ADDR_STEER: str_q <= wdata_i[3:0];
				default:              ;
			endcase
		end
	end
	wire logic [5:0] src_on = ~{external_input_pin_i, timer_six_postscaled_i,
		timer_four_postscaled_i, timer_two_postscaled_i, comparator_two_result_i,
		comparator_one_result_i} & as1_q;
	wire logic bridge = con0_q[7] && con0_q[2:0] >= wdss_pkg::MODE_FWD
		&& con0_q[2:0] <= wdss_pkg::MODE_PUSH;
	// ==========
	// properties
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_at(logic [3:0] a);
		rd_i && addr_i == a;
	endsequence
	sequence src_held(logic f);
		(bridge && f && |src_on) [*8];
	endsequence
	reset_state_a: assert property (disable iff (1'b0)
		rst_i |=> out_oe_n_o == 4'hf && out_o == 4'h0 && rdata_o == 8'h00)
		else $error("outputs not idle after reset");
	read_idle_a: assert property (
		!rd_i |=> rdata_o == 8'h00) else $error("read data without read");
	ctrl_readback_a: assert property (
		rd_at(wdss_pkg::ADDR_CON0) |=> rdata_o[7] == con0_q[7]
		&& rdata_o[5:0] == {3'h0, con0_q[2:0]}) else $error("control zero readback");
	src_sel_read_a: assert property (
		rd_at(wdss_pkg::ADDR_AS1) |=> rdata_o[7] == 1'b1 && rdata_o[5:0] == as1_q)
		else $error("source enable readback");
	unmapped_zero_a: assert property (
		rd_i && addr_i > wdss_pkg::ADDR_AS1 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	ovr_ac_level_a: assert property (
		src_held(as0_q[3]) |-> out_o[0] == as0_q[2] && out_o[2] == as0_q[2]
		&& out_oe_n_o[0] == 1'b0) else $error("a/c override level");
	ovr_bd_level_a: assert property (
		src_held(as0_q[5]) |-> out_o[1] == as0_q[4] && out_o[3] == as0_q[4]
		&& out_oe_n_o[3] == 1'b0) else $error("b/d override level");
	disabled_pins_a: assert property (
		!con0_q[7] [*2] |-> out_oe_n_o == 4'hf) else $error("pin driven while off");
	steer_fixed_a: assert property (
		(con0_q[7] && con0_q[2:0] == wdss_pkg::MODE_STEER && !str_q[1]) [*4]
		|-> out_o[1] == 1'b0 && out_oe_n_o[1] == 1'b0) else $error("fixed level lost");
endmodule
bind wdss_top wdss_props #(.DB_W(DB_W)) u_wdss_props (.clk_i(clk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.comparator_one_result_i(comparator_one_result_i),
	.comparator_two_result_i(comparator_two_result_i),
	.timer_two_postscaled_i(timer_two_postscaled_i),
	.timer_four_postscaled_i(timer_four_postscaled_i),
	.timer_six_postscaled_i(timer_six_postscaled_i),
	.external_input_pin_i(external_input_pin_i), .out_o(out_o), .out_oe_n_o(out_oe_n_o));
`default_nettype wire
